// [test/srv_dram_model.sv]
// Behavioural model of the two dynamic memory blocks
`timescale 1ns/100ps
module srv_dram_model (
  input wire logic                  clk,
  input wire srv_pkg::srv_dram_type dram,
  output logic [7:0]                rdData
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_r = 8'h00;
  logic       blk;
  logic       drive;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
  assign blk = (dram.casN == 2'h1);
  assign drive = !dram.rasN && dram.casN != 2'h3 && dram.weN;
  // Outputs only while a block's column strobe is low; else a toggling pattern
  always_comb rdData = drive ? mem[{blk, dram.addr}] : ~last_r;
  // Plain always: the initial fill also writes mem
  always @(posedge clk) begin
    last_r <= rdData;
    if (!dram.rasN && dram.casN != 2'h3 && !dram.weN) begin
      mem[{blk, dram.addr}] <= dram.wrData;
    end
  end
endmodule // srv_dram_model

// [test/srv_video_fetch_bench.sv]
// Self-checking bench for the shared video fetch block
`timescale 1ns/100ps
module srv_video_fetch_bench;
  localparam int REFRESH_CLKS = 4000;
  logic                     clk, reset, cpuRdValid_r, cpuDataOeN_r, cycleStart_r, scratchHit_r, vtcCharClk_r;
  logic                     charAddrBit0Delayed_r, dotTick_r, cursorBlank_r, refreshOk_r;
  logic                     dotRateSelect, graphicEnableN, textEnable, textPixel, f, h;
  logic [7:0]               cpuRdData_r, dramRdData, charCode_r;
  logic [4:0]               cursorRow;
  logic [6:0]               cursorCol;
  logic [10:0]              cursorOffset_r;
  srv_pkg::srv_cpu_req_type cpuReq;
  srv_pkg::srv_vtc_type     vtcAddr;
  srv_pkg::srv_dram_type    dram_r;
  srv_pkg::srv_video_type   video_r;
  int                       failures, n_checks, cycles, n, m;
  localparam logic [15:0] CA [7] = '{16'he000, 16'he001, 16'he002, 16'he003, 16'he6df, 16'he6e0, 16'he7ff};
  localparam logic [24:0] CUR [6] = '{{1'b0, 5'h0f, 7'h00, 11'h3c0, 1'b0}, {1'b0, 5'h00, 7'h27, 11'h027, 1'b0},
    {1'b0, 5'h01, 7'h28, 11'h068, 1'b1}, {1'b0, 5'h00, 7'h3f, 11'h03f, 1'b1}, {1'b1, 5'h15, 7'h4f, 11'h6df, 1'b0},
    {1'b1, 5'h01, 7'h00, 11'h050, 1'b0}};
  localparam logic [12:0] GFX [4] = '{{3'b100, 8'hff, 2'b00}, {3'b000, 8'h00, 2'b00}, {3'b000, 8'hff, 2'b10},
    {3'b010, 8'hff, 2'b01}};
  srv_video_fetch #(.REFRESH_CLKS(REFRESH_CLKS)) u_dut (.clk(clk), .reset(reset), .cpuReq(cpuReq),
    .cpuRdData_r(cpuRdData_r), .cpuRdValid_r(cpuRdValid_r), .cpuDataOeN_r(cpuDataOeN_r), .cycleStart_r(cycleStart_r),
    .scratchHit_r(scratchHit_r), .vtcAddr(vtcAddr), .vtcCharClk_r(vtcCharClk_r), .dram_r(dram_r),
    .dramRdData(dramRdData), .dotRateSelect(dotRateSelect), .graphicEnableN(graphicEnableN), .textEnable(textEnable),
    .textPixel(textPixel), .charCode_r(charCode_r), .charAddrBit0Delayed_r(charAddrBit0Delayed_r),
    .dotTick_r(dotTick_r), .video_r(video_r), .cursorRow(cursorRow), .cursorCol(cursorCol),
    .cursorOffset_r(cursorOffset_r), .cursorBlank_r(cursorBlank_r), .refreshOk_r(refreshOk_r));
  srv_dram_model u_dram (.clk(clk), .dram(dram_r), .rdData(dramRdData));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      $display("ERROR timeout expected finish seen hang");
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Returns at the falling edge inside a cycle-start clock
  task automatic cyc(input int k);
    repeat (k) begin
      @(negedge clk);
      while (cycleStart_r !== 1'b1) @(negedge clk);
    end
  endtask
  // Request stands over the taking edge only; the answer is a one-clock pulse
  task automatic cpu(input logic [15:0] a, input logic rnw, input logic [7:0] d, output logic [8:0] q);
    cyc(1);
    cpuReq = '{a, d, rnw, 1'b1};
    q = 9'h000;
    @(negedge clk);
    cpuReq.valid = 1'b0;
    repeat (13) begin
      @(negedge clk);
      if (cpuRdValid_r === 1'b1) q = {1'b1, cpuRdData_r};
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [8:0] q;
    cpu(a, 1'b0, d, q);
  endtask
  task automatic rd(input string what, input logic [15:0] a, input logic [8:0] e);
    logic [8:0] q;
    cpu(a, 1'b1, 8'h00, q);
    chk(what, {7'h00, e}, {7'h00, q});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    n_checks = 0;
    cycles = 0;
    reset = 1'b1;
    cpuReq = '0;
    vtcAddr = '0;
    {dotRateSelect, graphicEnableN, textEnable, textPixel, cursorRow, cursorCol} = {4'b0100, 12'h000};
    repeat (8) @(negedge clk);
    chk("reset strobes", 16'h003e, {10'h000, dram_r.rasN, dram_r.casN, dram_r.weN, cpuDataOeN_r, cpuRdValid_r});
    reset = 1'b0;
    wr(16'h0123, 8'h3c);
    wr(16'h4123, 8'hc3);
    rd("block0", 16'h0123, 9'h13c);
    rd("block1", 16'h4123, 9'h1c3);
    $display("Test dram done");
    for (int i = 0; i < 7; i++) begin
      wr(CA[i], CA[i][7:0] ^ 8'h5a);
      chk("scratch", {15'h0000, i > 4}, {15'h0000, scratchHit_r});
    end
    for (int i = 0; i < 7; i++) rd("char mem", CA[i], {1'b1, CA[i][7:0] ^ 8'h5a});
    rd("unmapped", 16'h9000, 9'h000);
    rd("above char", 16'he800, 9'h000);
    $display("Test char memory done");
    for (int b = 0; b < 2; b++) begin
      vtcAddr = '{14'h0002 | 14'(b), 4'h0};
      cyc(4);
      chk("char code", {8'h00, CA[2 + b][7:0] ^ 8'h5a}, {8'h00, charCode_r});
      chk("latch select", 16'(b), {15'h0000, charAddrBit0Delayed_r});
    end
    $display("Test char pair done");
    for (int r = 0; r < 2; r++) begin
      dotRateSelect = r[0];
      cyc(2);
      n = 0;
      m = 0;
      repeat (25) begin
        n += dotTick_r;
        m += vtcCharClk_r;
        @(negedge clk);
      end
      chk("dots per cycle", r ? 16'h0010 : 16'h0008, 16'(n));
      chk("char clocks", r ? 16'h0002 : 16'h0001, 16'(m));
    end
    $display("Test dot rate done");
    for (int i = 0; i < 6; i++) begin
      {dotRateSelect, cursorRow, cursorCol} = CUR[i][24:12];
      cyc(1);
      chk("cursor offset", {5'h00, CUR[i][11:1]}, {5'h00, cursorOffset_r});
      chk("cursor blank", {15'h0000, CUR[i][0]}, {15'h0000, cursorBlank_r});
    end
    $display("Test layout done");
    dotRateSelect = 1'b0;
    vtcAddr = '{14'h0005, 4'h3};
    wr(16'h0028, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(16'h00c5, GFX[i][9:2]);
      {graphicEnableN, textEnable, textPixel} = GFX[i][12:10];
      cyc(2);
      {f, h} = 2'b00;
      repeat (75) begin
        @(negedge clk);
        f |= video_r.full;
        h |= video_r.half;
      end
      chk("graphic video", {14'h0000, GFX[i][1:0]}, {14'h0000, f, h});
    end
    {graphicEnableN, textEnable} = 2'b10;
    $display("Test graphic done");
    for (int k = 0; k < 480; k++) begin
      vtcAddr = '{{9'h000, k[3:0], 1'b0}, {1'b0, k[6:4]}}; // Programmed controller's row sweep
      cyc(1);
    end
    chk("refresh sweep", 16'h0001, {15'h0000, refreshOk_r});
    cyc(400);
    chk("refresh stall", 16'h0000, {15'h0000, refreshOk_r});
    $display("Test refresh done");
    final_report();
  end
endmodule // srv_video_fetch_bench
bind srv_video_fetch srv_video_fetch_monitor u_mon (.clk(clk), .reset(reset), .cpuReq(cpuReq),
  .cpuRdValid_r(cpuRdValid_r), .cpuDataOeN_r(cpuDataOeN_r), .cycleStart_r(cycleStart_r), .dram_r(dram_r));

// [test/srv_video_fetch_monitor.sv]
// Port-level checks of the shared video fetch block
`timescale 1ns/100ps
module srv_video_fetch_monitor (
  input wire logic                     clk,
  input wire logic                     reset,
  input wire srv_pkg::srv_cpu_req_type cpuReq,
  input wire logic                     cpuRdValid_r,
  input wire logic                     cpuDataOeN_r,
  input wire logic                     cycleStart_r,
  input wire srv_pkg::srv_dram_type    dram_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       rasPrev_r;
  logic [1:0] rasFalls_r;
  ////////////////////////////////////////////////////////////////////////////
  // Row strobe openings since the last cycle start; saturates so it never wraps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rasPrev_r  <= 1'b1;
      rasFalls_r <= 2'h0;
    end else begin
      rasPrev_r <= dram_r.rasN;
      if (cycleStart_r) begin
        rasFalls_r <= 2'h0;
      end else if (rasPrev_r && !dram_r.rasN && rasFalls_r != 2'h3) begin
        rasFalls_r <= rasFalls_r + 2'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence quietGap;
    !cycleStart_r [*8];
  endsequence
  sequence readTaken;
    cycleStart_r && cpuReq.valid && cpuReq.readNotWrite && (!cpuReq.addr[15] || cpuReq.addr[15:11] == 5'h1c);
  endsequence
  sequence writeTaken;
    cycleStart_r && cpuReq.valid && !cpuReq.readNotWrite;
  endsequence
  chk_cycle_period: assert property (cycleStart_r |=> quietGap ##17 cycleStart_r)
    else $error("processor cycle is not 25 clocks");
  chk_refresh_strobe: assert property (cycleStart_r |-> rasFalls_r == 2'h2)
    else $error("row strobe count per cycle wrong");
  chk_read_answer: assert property (readTaken |-> ##11 cpuRdValid_r)
    else $error("read answer late or missing");
  chk_no_stray: assert property (cpuRdValid_r |-> $past(cpuReq.valid, 11) && $past(cpuReq.readNotWrite, 11))
    else $error("read answer without a read");
  chk_read_drive: assert property (readTaken |-> ##[2:4] !cpuDataOeN_r)
    else $error("data switch not driving on read");
  chk_write_quiet: assert property (writeTaken |-> cpuDataOeN_r [*8])
    else $error("data switch driven during write");
  chk_write_strobe: assert property (writeTaken ##0 !cpuReq.addr[15] |-> ##[1:6] (!dram_r.weN && !dram_r.rasN))
    else $error("memory write strobe missing");
  chk_idle_phase: assert property (cycleStart_r |-> dram_r.rasN && dram_r.casN == 2'h3 && dram_r.weN)
    else $error("strobes active at cycle start");
  chk_cas_in_row: assert property (dram_r.casN != 2'h3 |-> !dram_r.rasN)
    else $error("column strobe without row strobe");
endmodule // srv_video_fetch_monitor

// [verilog/srv_map.svh]
// Offsets, field positions, sizes and timing counts of the shared video fetch block
`ifndef SRV_MAP_SVH
`define SRV_MAP_SVH
`define SRV_CLK_NS 40
`define SRV_CPU_CYC_NS 1000
`define SRV_CYC_CLKS ((`SRV_CPU_CYC_NS + `SRV_CLK_NS - 1) / `SRV_CLK_NS)
`define SRV_PH_W 5
`define SRV_CPU_RAS_ON 5'h01
`define SRV_CPU_CAS_ON 5'h04
`define SRV_CPU_DONE 5'h0a
`define SRV_VID_RAS_ON 5'h0e
`define SRV_VID_CAS_ON 5'h11
`define SRV_VID_DONE 5'h17
`define SRV_DOT_SPAN 5'h10
`define SRV_REFRESH_US 512
`define SRV_REFRESH_CLKS (`SRV_REFRESH_US * 1000 / `SRV_CLK_NS)
`define SRV_DRAM_ROWS 128
`define SRV_DRAM_TOP 16'h8000
`define SRV_CHAR_BASE 16'he000
`define SRV_SCREEN_BYTES 11'h6e0
`define SRV_ROW40 11'h040
`define SRV_ROW80 11'h050
`define SRV_VIS40 7'h28
`define SRV_GFX_BLK 1'b0
`endif

// [verilog/srv_pkg.sv]
// Types shared by the shared video fetch block
package srv_pkg;
  typedef enum logic {SLOT_CPU, SLOT_VIDEO} srv_slot_type;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wrData;
    logic        readNotWrite;
    logic        valid;
  } srv_cpu_req_type;
  typedef struct packed {
    logic [13:0] addr;
    logic        rasN;
    logic [1:0]  casN;
    logic        weN;
    logic [7:0]  wrData;
  } srv_dram_type;
  typedef struct packed {
    logic [13:0] charAddr;
    logic [3:0]  rasterLine;
  } srv_vtc_type;
  typedef struct packed {
    logic full;
    logic half;
  } srv_video_type;
endpackage

// [verilog/srv_video_fetch.sv]
// Shared display memory arbiter, character and bitmap fetch, dot timing and mixer
//
// Overview of operation
// - Each processor cycle split into processor, video slots
// - Video slot address from raster and character address
// - Controller row sequence refreshes 128 rows, 512us
// - Row strobe every cycle; data only with column strobe
// - Video fetch happens exactly once per processor cycle
// - 1760 screen bytes, 288 bytes scratchpad
// - Character memory as even and odd banks
// - Address bit 0 picks bank, bits 10..1 index
// - Data switch direction follows read/write-not
// - Two latches alternate on delayed address bit 0
// - Dots 16 MHz or 8 MHz by rate select
// - 40-column rows stride 0x40, columns 40+ blank
// - 80-column rows packed at stride 0x50
// - Character offsets counted from base E000
// - 40-column line has 64 character times, 40 visible
// - Bitmap 320 dots wide, 40 bytes, 256 scans
// - Graphic byte loaded and shifted out dot by dot
// - Graphic at half intensity when text also shown
`timescale 1ns/100ps
`include "srv_map.svh"
module srv_video_fetch #(
  parameter int REFRESH_CLKS = `SRV_REFRESH_CLKS
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire srv_pkg::srv_cpu_req_type cpuReq,
  output logic [7:0]                   cpuRdData_r,
  output logic                         cpuRdValid_r,
  output logic                         cpuDataOeN_r,
  output logic                         cycleStart_r,
  output logic                         scratchHit_r,
  input  wire srv_pkg::srv_vtc_type    vtcAddr,
  output logic                         vtcCharClk_r,
  output srv_pkg::srv_dram_type        dram_r,
  input  wire logic [7:0]              dramRdData,
  input  wire logic                    dotRateSelect,
  input  wire logic                    graphicEnableN,
  input  wire logic                    textEnable,
  input  wire logic                    textPixel,
  output logic [7:0]                   charCode_r,
  output logic                         charAddrBit0Delayed_r,
  output logic                         dotTick_r,
  output srv_pkg::srv_video_type       video_r,
  input  wire logic [4:0]              cursorRow,
  input  wire logic [6:0]              cursorCol,
  output logic [10:0]                  cursorOffset_r,
  output logic                         cursorBlank_r,
  output logic                         refreshOk_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the control port bits
  logic [2:0] pinMeta_r;
  logic [2:0] pinSync_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinMeta_r <= 3'h2;
      pinSync_r <= 3'h2;
    end else begin
      pinMeta_r <= {textEnable, graphicEnableN, dotRateSelect};
      pinSync_r <= pinMeta_r;
    end
  end
  logic rate80;
  logic gfxOn;
  logic textOn;
  assign rate80 = pinSync_r[0];
  assign gfxOn  = ~pinSync_r[1];
  assign textOn = pinSync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Timing chain: one processor cycle of fixed length
  logic [`SRV_PH_W-1:0] phase_r;
  srv_pkg::srv_slot_type slot;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r <= '0;
    end else if (phase_r == `SRV_PH_W'(`SRV_CYC_CLKS - 1)) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + `SRV_PH_W'(1);
    end
  end
  // Both selects decode the same counter, so slots never drift
  assign slot = (phase_r < `SRV_VID_RAS_ON - 5'h01) ? srv_pkg::SLOT_CPU : srv_pkg::SLOT_VIDEO;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cycleStart_r <= 1'b0;
    end else begin
      cycleStart_r <= (phase_r == `SRV_PH_W'(`SRV_CYC_CLKS - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor request capture and decode
  srv_pkg::srv_cpu_req_type cpuLat_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuLat_r <= '0;
    end else if (phase_r == '0) begin
      cpuLat_r <= cpuReq;
    end
  end
  logic dramHit;
  logic charHit;
  logic [15:0] charOfs;
  assign dramHit = cpuLat_r.valid & (cpuLat_r.addr < `SRV_DRAM_TOP);
  assign charOfs = cpuLat_r.addr - `SRV_CHAR_BASE;
  assign charHit = cpuLat_r.valid & (cpuLat_r.addr[15:11] == 5'(`SRV_CHAR_BASE >> 11));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scratchHit_r <= 1'b0;
    end else if (phase_r == `SRV_CPU_CAS_ON) begin
      scratchHit_r <= charHit & (charOfs[10:0] >= `SRV_SCREEN_BYTES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic RAM strobes, one processor and one video access per cycle
  logic [13:0] vidAddr;
  // Raster line replaces bits 9..6, character address fills the rest
  assign vidAddr = {vtcAddr.charAddr[9:6], vtcAddr.rasterLine, vtcAddr.charAddr[5:0]};
  logic [7:0] gfxFetch_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dram_r     <= '{addr: 14'h0, rasN: 1'b1, casN: 2'h3, weN: 1'b1, wrData: 8'h0};
      gfxFetch_r <= 8'h0;
    end else begin
      case (phase_r)
        `SRV_CPU_RAS_ON: begin
          dram_r.addr   <= cpuLat_r.addr[13:0];
          dram_r.rasN   <= 1'b0;
          dram_r.weN    <= ~(dramHit & ~cpuLat_r.readNotWrite);
          dram_r.wrData <= cpuLat_r.wrData;
        end
        `SRV_CPU_CAS_ON: begin
          if (dramHit && slot == srv_pkg::SLOT_CPU) begin
            dram_r.casN[cpuLat_r.addr[14]] <= 1'b0;
          end
        end
        `SRV_CPU_DONE, `SRV_VID_DONE: begin
          dram_r.rasN <= 1'b1;
          dram_r.casN <= 2'h3;
          dram_r.weN  <= 1'b1;
          if (phase_r == `SRV_VID_DONE) begin
            gfxFetch_r <= gfxOn ? dramRdData : 8'h0;
          end
        end
        `SRV_VID_RAS_ON: begin
          dram_r.addr <= vidAddr;
          dram_r.rasN <= 1'b0; // Refresh comes free with each video row
        end
        `SRV_VID_CAS_ON: begin
          // Without column strobe the block keeps its outputs off
          if (gfxOn) begin
            dram_r.casN[`SRV_GFX_BLK] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character memory: even and odd banks of 1K bytes
  logic [7:0] evenBank [0:1023];
  logic [7:0] oddBank  [0:1023];
  logic [9:0] cpuIdx;
  logic [9:0] vidIdx;
  assign cpuIdx = cpuLat_r.addr[10:1];
  assign vidIdx = vtcAddr.charAddr[10:1];
  always_ff @(posedge clk) begin
    if (phase_r == `SRV_CPU_CAS_ON && charHit && !cpuLat_r.readNotWrite) begin
      if (cpuLat_r.addr[0]) begin
        oddBank[cpuIdx] <= cpuLat_r.wrData;
      end else begin
        evenBank[cpuIdx] <= cpuLat_r.wrData;
      end
    end
  end

  logic [7:0] charRd_r;
  logic [7:0] pairLo_r;
  logic [7:0] pairHi_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      charRd_r <= 8'h0;
      pairLo_r <= 8'h0;
      pairHi_r <= 8'h0;
    end else begin
      if (phase_r == `SRV_CPU_CAS_ON) begin
        charRd_r <= cpuLat_r.addr[0] ? oddBank[cpuIdx] : evenBank[cpuIdx];
      end
      if (phase_r == `SRV_VID_CAS_ON) begin
        pairLo_r <= evenBank[vidIdx]; // One 16-bit pair per cycle
        pairHi_r <= oddBank[vidIdx];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor read return and data switch direction
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuRdData_r  <= 8'h0;
      cpuRdValid_r <= 1'b0;
      cpuDataOeN_r <= 1'b1;
    end else begin
      cpuRdValid_r <= 1'b0;
      if (phase_r == `SRV_CPU_RAS_ON) begin
        cpuDataOeN_r <= ~(cpuLat_r.readNotWrite & (dramHit | charHit));
      end else if (phase_r == `SRV_CPU_DONE) begin
        cpuDataOeN_r <= 1'b1;
        cpuRdData_r  <= charHit ? charRd_r : dramRdData;
        cpuRdValid_r <= cpuLat_r.readNotWrite & (dramHit | charHit);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dot and character timing
  // The 25 MHz clock only approximates the dot rate: 16 or 8 dots per cycle
  logic dotNow;
  assign dotNow = (phase_r < `SRV_DOT_SPAN) & (rate80 | ~phase_r[0]);
  logic [2:0] dotIdx_r;
  logic       ma0Prev_r;
  logic [7:0] latLo_r;
  logic [7:0] latHi_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dotTick_r    <= 1'b0;
      dotIdx_r     <= 3'h0;
      vtcCharClk_r <= 1'b0;
      ma0Prev_r    <= 1'b0;
      charAddrBit0Delayed_r <= 1'b0;
      charCode_r   <= 8'h0;
      latLo_r      <= 8'h0;
      latHi_r      <= 8'h0;
    end else begin
      dotTick_r    <= dotNow;
      vtcCharClk_r <= dotNow & (dotIdx_r == 3'h0);
      if (phase_r == '0) begin
        latLo_r <= pairLo_r;
        latHi_r <= pairHi_r;
      end
      if (dotNow) begin
        dotIdx_r <= dotIdx_r + 3'h1;
        if (dotIdx_r == 3'h0) begin
          // Bit 0 held back one character time picks the latch
          ma0Prev_r <= vtcAddr.charAddr[0];
          charAddrBit0Delayed_r <= ma0Prev_r;
          charCode_r <= ma0Prev_r ? latHi_r : latLo_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bitmap shifter and mixer
  logic [7:0] gfxShift_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gfxShift_r <= 8'h0;
    end else if (phase_r == '0) begin
      gfxShift_r <= gfxFetch_r;
    end else if (dotNow) begin
      gfxShift_r <= {gfxShift_r[6:0], 1'b0}; // One bit per dot
    end
  end
  logic gfxDot;
  assign gfxDot = gfxOn & gfxShift_r[7];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      video_r <= '0;
    end else begin
      video_r.full <= (textOn & textPixel) | (gfxDot & ~textOn);
      video_r.half <= gfxDot & textOn & ~textPixel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Screen position to character offset
  logic [10:0] rowBase;
  assign rowBase = rate80 ? 11'(cursorRow * `SRV_ROW80) : 11'(cursorRow * `SRV_ROW40);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cursorOffset_r <= 11'h0;
      cursorBlank_r  <= 1'b0;
    end else begin
      cursorOffset_r <= rowBase + {4'h0, cursorCol};
      cursorBlank_r  <= ~rate80 & (cursorCol >= `SRV_VIS40);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh coverage over each window
  logic [`SRV_DRAM_ROWS-1:0] rowSeen_r;
  logic [`SRV_DRAM_ROWS-1:0] rowNow;
  logic [13:0]               refCnt_r;
  always_comb begin
    rowNow = '0;
    if (phase_r == `SRV_VID_RAS_ON) begin
      rowNow[{vtcAddr.rasterLine[2:0], vtcAddr.charAddr[4:1]}] = 1'b1;
    end else if (phase_r == `SRV_CPU_RAS_ON) begin
      rowNow[{cpuLat_r.addr[8:6], cpuLat_r.addr[4:1]}] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rowSeen_r   <= '0;
      refCnt_r    <= 14'h0;
      refreshOk_r <= 1'b0;
    end else if (refCnt_r == 14'(REFRESH_CLKS - 1)) begin
      refCnt_r    <= 14'h0;
      refreshOk_r <= &(rowSeen_r | rowNow);
      rowSeen_r   <= rowNow;
    end else begin
      refCnt_r  <= refCnt_r + 14'h1;
      rowSeen_r <= rowSeen_r | rowNow;
    end
  end

endmodule // srv_video_fetch
